// file: pkg/valley_cycle_defs.vh
/*
 * Constants for the valley-switching cycle controller: time windows in
 * their own units and the clock rate from which cycle counts derive.
 * Assumes a 200 MHz system clock.
 */
`ifndef VALLEY_CYCLE_DEFS_VH
`define VALLEY_CYCLE_DEFS_VH

`define CLOCK_MHZ 200
`define MIN_PERIOD_NS 8000
`define BLANK_NS 3000
`define WATCHDOG_NS 50000
`define TIMEOUT_NS 8000
`define SOFT_START_US 5000
`define NS_PER_US 1000
// Least times round up, the watchdog (a longest time) rounds down.
`define MIN_PERIOD_CYC ((`MIN_PERIOD_NS * `CLOCK_MHZ + 999) / 1000)
`define BLANK_CYC ((`BLANK_NS * `CLOCK_MHZ + 999) / 1000)
`define WATCHDOG_CYC ((`WATCHDOG_NS * `CLOCK_MHZ) / 1000)
`define TIMEOUT_CYC ((`TIMEOUT_NS * `CLOCK_MHZ + 999) / 1000)
`define SOFT_START_CYC (`SOFT_START_US * `CLOCK_MHZ)
`define SOFT_START_WIDTH 8
`define SOFT_START_MAX 8'hFF

`endif

// file: logic/sync_edge.v
/*
 * Two-flop synchroniser for one comparator input, with a falling-edge
 * pulse taken from the second and third stages.
 * Assumes the input is an asynchronous level from an analog comparator.
 */
`timescale 1ns/1ps
module sync_edge (
    input wire clock, // System clock.
    input wire rstn, // Asynchronous reset, active low.
    input wire asyncIn, // Raw comparator level.
    output reg syncOut, // Synchronised level.
    output wire fallPulse // One-cycle pulse on a falling edge.
);
    reg meta_reg;
    reg last_reg;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            syncOut <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= asyncIn;
            syncOut <= meta_reg;
            last_reg <= syncOut;
        end
    end

    assign fallPulse = last_reg & ~syncOut;
endmodule // sync_edge

// file: logic/valley_switching_cycle_control.v
/*
 * Cycle control of a valley-switching flyback controller: drive flip-flop,
 * minimum-period window, no-ringing timeout, leakage blanking, on-time
 * watchdog and skip gating with soft-start restart.
 * Assumes analog comparators and the gate driver outside; one clock.
 */
// Summary of operation
// - Each gate turn-on starts an 8 us minimum-period timer.
// - Peak-current trip while driving resets the drive flip-flop low.
// - Gate high over 50 us stops pulses, enters a fault held until faultRestart.
// - A 3 us blanking window after turn-off suppresses any restart.
// - Falling demagnetization comparator edge clocks the drive flip-flop.
// - Demag edges before the minimum period ends are ignored.
// - Skip reset latches restarts; a latched one drives high at release.
// - Skip comparator high holds the drive flip-flop reset.
// - Pulsing resumes when the skip comparator releases above hysteresis.
// - Each skip release retriggers the soft-start ramp.
// - No-ringing timeout clears on every crossing and turn-on, counts otherwise.
// - After 8 us without crossings the timeout grants restart.
// - Timeout grant holds until period, blanking, skip reset and fault allow restart.
// - Soft-start ramps the peak setpoint from minimum to maximum in 5 ms.
`timescale 1ns/1ps
`include "valley_cycle_defs.vh"
module valley_switching_cycle_control #(
    parameter MIN_PERIOD_CYCLES = `MIN_PERIOD_CYC,
    parameter BLANK_CYCLES = `BLANK_CYC,
    parameter WATCHDOG_CYCLES = `WATCHDOG_CYC,
    parameter TIMEOUT_CYCLES = `TIMEOUT_CYC,
    parameter SOFT_START_CYCLES = `SOFT_START_CYC,
    parameter SS_WIDTH = `SOFT_START_WIDTH
) (
    input wire clock, // 200 MHz system clock.
    input wire rstn, // Asynchronous reset, active low.
    input wire demagComp, // High while auxiliary winding above threshold.
    input wire peakTrip, // High when sense current reaches setpoint.
    input wire skipComp, // High while feedback at or below skip level.
    input wire faultRestart, // External restart that clears the fault.
    output reg gate_drive_out, // Gate drive to the power switch.
    output reg faultActive, // Watchdog fault state.
    output reg softStartBusy, // Soft-start ramp in progress.
    output reg [SS_WIDTH-1:0] peakSetpoint // Soft-start peak limit.
);
    localparam CW = 24;
    // Terminal counts are worked out at 32 bits and cut to the counter
    // width on purpose; every documented window fits well inside 24 bits.
    localparam [31:0] MIN_LAST_W = MIN_PERIOD_CYCLES - 1;
    localparam [31:0] BLANK_LAST_W = BLANK_CYCLES - 1;
    localparam [31:0] WD_LAST_W = WATCHDOG_CYCLES - 1;
    localparam [31:0] TO_LAST_W = TIMEOUT_CYCLES - 1;
    // Any remainder of the ramp length over the code count is dropped, so
    // the ramp may end a few cycles before its nominal length.
    localparam [31:0] STEP_CYC_W = SOFT_START_CYCLES / ((1 << SS_WIDTH) - 1);
    localparam [31:0] STEP_LAST_W = STEP_CYC_W - 1;
    localparam [CW-1:0] MIN_LAST = MIN_LAST_W[CW-1:0];
    localparam [CW-1:0] BLANK_LAST = BLANK_LAST_W[CW-1:0];
    localparam [CW-1:0] WD_LAST = WD_LAST_W[CW-1:0];
    localparam [CW-1:0] TO_LAST = TO_LAST_W[CW-1:0];
    localparam [CW-1:0] STEP_LAST = STEP_LAST_W[CW-1:0];
    localparam [SS_WIDTH-1:0] SS_MAX = {SS_WIDTH{1'b1}};

    wire demagSync;
    wire demagFall;
    wire peakSync;
    wire skipSync;
    wire skipRelease;

    sync_edge demagSyncer (
        .clock(clock),
        .rstn(rstn),
        .asyncIn(demagComp),
        .syncOut(demagSync),
        .fallPulse(demagFall)
    );
    sync_edge peakSyncer (
        .clock(clock),
        .rstn(rstn),
        .asyncIn(peakTrip),
        .syncOut(peakSync),
        .fallPulse()
    );
    sync_edge skipSyncer (
        .clock(clock),
        .rstn(rstn),
        .asyncIn(skipComp),
        .syncOut(skipSync),
        .fallPulse(skipRelease)
    );

    // All window counters share one width; CW must hold the longest window.
    reg [CW-1:0] periodCnt_reg;
    reg periodDone_reg;
    reg [CW-1:0] blankCnt_reg;
    reg blankDone_reg;
    reg [CW-1:0] onCnt_reg;
    reg [CW-1:0] toCnt_reg;
    reg timeoutGrant_reg;
    reg pending_reg;
    reg [CW-1:0] stepCnt_reg;

    // Restart permission: a valley edge or the timeout grant, latched so a
    // grant that arrives during skip still fires once skip releases.
    wire restartEvent = demagFall | timeoutGrant_reg;
    wire allowed = periodDone_reg & blankDone_reg & ~skipSync
        & ~faultActive;
    wire turnOn = ~gate_drive_out & allowed
        & (restartEvent | pending_reg);
    wire wdTrip = gate_drive_out & (onCnt_reg == WD_LAST);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gate_drive_out <= 1'b0;
            faultActive <= 1'b0;
            periodCnt_reg <= {CW{1'b0}};
            periodDone_reg <= 1'b1;
            blankCnt_reg <= {CW{1'b0}};
            blankDone_reg <= 1'b1;
            onCnt_reg <= {CW{1'b0}};
            toCnt_reg <= {CW{1'b0}};
            timeoutGrant_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            // Drive flip-flop. The watchdog outranks every other input so a
            // stuck switch is cut in the cycle it expires, whatever the
            // comparators report.
            if (wdTrip) begin
                gate_drive_out <= 1'b0;
            end else if (gate_drive_out & (peakSync | skipSync)) begin
                gate_drive_out <= 1'b0;
            end else if (turnOn) begin
                gate_drive_out <= 1'b1;
            end

            // A watchdog expiry in the same cycle as a restart request
            // leaves the fault standing.
            if (wdTrip) begin
                faultActive <= 1'b1;
            end else if (faultRestart) begin
                faultActive <= 1'b0;
            end

            // Minimum period measured turn-on to turn-on. The window ends
            // one cycle after the terminal count, so the gap comes out one
            // cycle longer than the minimum, never shorter.
            if (turnOn) begin
                periodCnt_reg <= {CW{1'b0}};
                periodDone_reg <= 1'b0;
            end else if (!periodDone_reg) begin
                periodCnt_reg <= periodCnt_reg + 1'b1;
                if (periodCnt_reg == MIN_LAST) begin
                    periodDone_reg <= 1'b1;
                end
            end

            // Leakage blanking after every turn-off. Restart is refused
            // until the cycle after the terminal count.
            if (gate_drive_out & (wdTrip | peakSync | skipSync)) begin
                blankCnt_reg <= {CW{1'b0}};
                blankDone_reg <= 1'b0;
            end else if (!blankDone_reg) begin
                blankCnt_reg <= blankCnt_reg + 1'b1;
                if (blankCnt_reg == BLANK_LAST) begin
                    blankDone_reg <= 1'b1;
                end
            end

            // On-time watchdog. The count restarts whenever the gate is low,
            // so it measures one continuous on-time and not a total.
            if (gate_drive_out) begin
                onCnt_reg <= onCnt_reg + 1'b1;
            end else begin
                onCnt_reg <= {CW{1'b0}};
            end

            // No-ringing timeout: cleared by every crossing. A turn-on also
            // clears it, so one stretch of silence grants only one restart.
            if (demagFall | turnOn) begin
                toCnt_reg <= {CW{1'b0}};
                timeoutGrant_reg <= 1'b0;
            end else if (!timeoutGrant_reg) begin
                toCnt_reg <= toCnt_reg + 1'b1;
                if (toCnt_reg == TO_LAST) begin
                    timeoutGrant_reg <= 1'b1;
                end
            end

            // An edge refused only for skip is remembered; period or
            // blanking refusals are dropped so the next valley is used.
            if (turnOn | ~skipSync) begin
                pending_reg <= 1'b0;
            end else if (restartEvent & periodDone_reg & blankDone_reg) begin
                pending_reg <= 1'b1;
            end
        end
    end

    // Soft-start ramp, retriggered at reset release and on skip release.
    // Skip release outranks the ramp end, so every restart begins at the
    // floor even when the previous ramp finishes in the same cycle.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            peakSetpoint <= {SS_WIDTH{1'b0}};
            softStartBusy <= 1'b1;
            stepCnt_reg <= {CW{1'b0}};
        end else if (skipRelease) begin
            peakSetpoint <= {SS_WIDTH{1'b0}};
            softStartBusy <= 1'b1;
            stepCnt_reg <= {CW{1'b0}};
        end else if (softStartBusy) begin
            if (stepCnt_reg == STEP_LAST) begin
                stepCnt_reg <= {CW{1'b0}};
                peakSetpoint <= peakSetpoint + 1'b1;
                if (peakSetpoint == SS_MAX - 1'b1) begin
                    softStartBusy <= 1'b0;
                end
            end else begin
                stepCnt_reg <= stepCnt_reg + 1'b1;
            end
        end
    end
endmodule // valley_switching_cycle_control

// file: bench/valley_cycle_asserts.sv
/* Port checker for the cycle controller.
   Bound to every instance of the controller at the foot of this file. */
`timescale 1ns/1ps
module valley_cycle_asserts #(
    parameter MIN_PERIOD_CYCLES = 40,
    parameter BLANK_CYCLES = 15,
    parameter WATCHDOG_CYCLES = 200,
    parameter SS_WIDTH = 8
) (
    input wire clock, // Clock.
    input wire rstn, // Reset, active low.
    input wire peakTrip, // Peak comparator.
    input wire skipComp, // Skip comparator.
    input wire faultRestart, // Fault clear.
    input wire gate_drive_out, // Gate drive.
    input wire faultActive, // Fault state.
    input wire softStartBusy, // Ramp running.
    input wire [SS_WIDTH-1:0] peakSetpoint // Ramp value.
);
    reg gatePrev;
    reg [15:0] onGap;
    reg [15:0] offGap;
    reg [15:0] hiRun;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gatePrev <= 1'b0;
            onGap <= 16'h8000;
            offGap <= 16'h8000;
            hiRun <= 16'h0000;
        end else begin
            gatePrev <= gate_drive_out;
            onGap <= (gate_drive_out && !gatePrev) ? 16'h0001
                : onGap + 16'h0001;
            offGap <= (!gate_drive_out && gatePrev) ? 16'h0001
                : offGap + 16'h0001;
            hiRun <= gate_drive_out ? hiRun + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_MIN_PERIOD: assert property (
        $rose(gate_drive_out) |-> onGap >= MIN_PERIOD_CYCLES)
        else $error("turn-on spacing too short");
    AST_PEAK_OFF: assert property (peakTrip [*3] |=> !gate_drive_out)
        else $error("gate stays on after peak trip");
    AST_WATCHDOG: assert property (
        gate_drive_out |-> hiRun < WATCHDOG_CYCLES)
        else $error("gate on too long");
    AST_FAULT_OFF: assert property (faultActive |=> !gate_drive_out)
        else $error("pulse during fault");
    AST_FAULT_HOLD: assert property (
        faultActive && !faultRestart |=> faultActive)
        else $error("fault cleared without restart");
    AST_BLANK: assert property (
        $rose(gate_drive_out) |-> offGap >= BLANK_CYCLES)
        else $error("restart inside blanking");
    AST_SKIP_OFF: assert property (skipComp [*3] |=> !gate_drive_out)
        else $error("gate on during skip");
    AST_SS_RESTART: assert property (
        $fell(skipComp) |-> ##[1:5] peakSetpoint == {SS_WIDTH{1'b0}})
        else $error("ramp not restarted");
    AST_SS_DONE: assert property (!softStartBusy |-> &peakSetpoint)
        else $error("ramp ended below top");
    COV_TURN_ON: cover property ($rose(gate_drive_out));
    COV_FAULT: cover property ($rose(faultActive));
    COV_SKIP_END: cover property ($fell(skipComp));
endmodule // valley_cycle_asserts
bind valley_switching_cycle_control valley_cycle_asserts #(
    .MIN_PERIOD_CYCLES(MIN_PERIOD_CYCLES), .BLANK_CYCLES(BLANK_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES), .SS_WIDTH(SS_WIDTH)
) u_valley_cycle_asserts (.clock(clock), .rstn(rstn), .peakTrip(peakTrip),
    .skipComp(skipComp), .faultRestart(faultRestart),
    .gate_drive_out(gate_drive_out), .faultActive(faultActive),
    .softStartBusy(softStartBusy), .peakSetpoint(peakSetpoint));

// file: bench/comparator_model.sv
/* Peak-current comparator stand-in: trips a set time after turn-on.
   Assumes the bench sets onCycles; zero models an open sense path. */
`timescale 1ns/1ps
module comparator_model (
    input wire clock, // Clock.
    input wire gate_drive_out, // Gate drive.
    input wire [7:0] onCycles, // Trip delay, 0 never trips.
    output wire peakTrip // Peak comparator.
);
    reg [7:0] onCount = 8'h00;
    always @(posedge clock) begin
        onCount <= gate_drive_out ? onCount + 8'h01 : 8'h00;
    end
    // Sense current collapses as soon as the switch opens.
    assign peakTrip = gate_drive_out && onCycles != 8'h00
        && onCount >= onCycles;
endmodule // comparator_model

// file: bench/valley_switching_cycle_control_tb.sv
/* Self-checking bench for the cycle controller.
   Assumes short windows: 40-cycle period and timeout, 15 blank and a
   200-cycle watchdog. */
`timescale 1ns/1ps
module valley_switching_cycle_control_tb;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg demagComp = 1'b0;
    reg skipComp = 1'b0;
    reg faultRestart = 1'b0;
    reg [7:0] onCycles = 8'h0A;
    wire peakTrip;
    wire gate_drive_out;
    wire faultActive;
    wire softStartBusy;
    wire [7:0] peakSetpoint;
    integer fails = 0;
    integer num_checks = 0;
    integer i;
    always #2.5 clock = ~clock;
    valley_switching_cycle_control #(.MIN_PERIOD_CYCLES(40), .BLANK_CYCLES(15),
        .WATCHDOG_CYCLES(200), .TIMEOUT_CYCLES(40), .SOFT_START_CYCLES(2550)
    ) u_valley_switching_cycle_control (.clock(clock), .rstn(rstn),
        .demagComp(demagComp), .peakTrip(peakTrip), .skipComp(skipComp),
        .faultRestart(faultRestart), .gate_drive_out(gate_drive_out),
        .faultActive(faultActive), .softStartBusy(softStartBusy),
        .peakSetpoint(peakSetpoint));
    comparator_model u_comparator_model (.clock(clock),
        .gate_drive_out(gate_drive_out), .onCycles(onCycles),
        .peakTrip(peakTrip));
    task cyc(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    // A wait that runs out ends the run rather than desynchronising the
    // later steps.
    task wait_gate(input lvl, input integer bound);
        i = 0;
        while (gate_drive_out !== lvl && i < bound) begin
            cyc(1);
            i = i + 1;
        end
        check(gate_drive_out, lvl);
        if (gate_drive_out !== lvl)
            print_verdict;
    endtask
    // One ringing crossing: a falling edge after two cycles above threshold.
    task ring;
        demagComp = 1'b1;
        cyc(2);
        demagComp = 1'b0;
    endtask
    task s_cycle;
        cyc(30);
        check(gate_drive_out, 8'h00);
        wait_gate(1, 20);
        wait_gate(0, 20);
        cyc(12);
        ring;
        cyc(6);
        check(gate_drive_out, 8'h00);
        cyc(17);
        check(gate_drive_out, 8'h00);
        ring;
        wait_gate(1, 8);
    endtask
    task s_skip;
        skipComp = 1'b1;
        wait_gate(0, 4);
        cyc(45);
        ring;
        cyc(6);
        check(gate_drive_out, 8'h00);
        skipComp = 1'b0;
        cyc(6);
        check(peakSetpoint, 8'h00);
        wait_gate(1, 40);
    endtask
    task s_fault;
        onCycles = 8'h00;
        wait_gate(0, 210);
        check(faultActive, 8'h01);
        cyc(45);
        ring;
        cyc(50);
        check(gate_drive_out, 8'h00);
        faultRestart = 1'b1;
        cyc(1);
        faultRestart = 1'b0;
        onCycles = 8'h0A;
        wait_gate(1, 60);
        check(faultActive, 8'h00);
    endtask
    // A late trip keeps the gate on past the period window, so only the
    // blanking window stands between turn-off and the timeout restart.
    task s_blank;
        onCycles = 8'h30;
        wait_gate(0, 60);
        cyc(10);
        check(gate_drive_out, 8'h00);
        wait_gate(1, 10);
        onCycles = 8'h0A;
    endtask
    task s_soft;
        i = 0;
        while (softStartBusy !== 1'b0 && i < 3000) begin
            cyc(1);
            i = i + 1;
        end
        check(softStartBusy, 8'h00);
        check(peakSetpoint, 8'hFF);
    endtask
    initial begin
        cyc(16);
        rstn = 1'b1;
        s_cycle;
        s_skip;
        s_fault;
        s_blank;
        s_soft;
        print_verdict;
    end
endmodule // valley_switching_cycle_control_tb
